// ===== hdl/aperture_delay_pkg.sv
// Purpose: constants for the aperture delay ramp controller
// Assumes: avalon-mm word registers, 40 MHz device clock
// Notes: Contract list below
// Contract
// - delay setting bit 16 set inverts the sampling clock, clear leaves it.
// - manual coarse code 15-8 applies while calibration is disabled or not yet complete.
// - with calibration enabled, the completed 17-bit calibration result is applied.
// - fine delay code lives in bits 7-0 and is applied as fine step.
// - ramp disabled: applied coarse reaches written code within 1024 clocks.
// - ramp enabled: applied coarse steps toward written value, then stops.
// - ramp steps one code per 256 clocks, or four when rate bit set.
// - ramp control: enable bit 0, rate bit 1, bits 7-2 reserved, reset zero.
// - delay setting bits 23-17 reserved writable; all fields reset zero.
package aperture_delay_pkg;
  localparam logic [11:0] delay_ramp_control_offs     = 12'h2b8;
  localparam logic [11:0] aperture_delay_setting_offs = 12'h2b4;
  localparam logic [11:0] cal_status_offs             = 12'h2bc;
  localparam logic [11:0] applied_delay_offs          = 12'h2c0;
  localparam logic [23:0] delay_setting_reset         = 24'h000000;
  localparam logic [7:0]  ramp_control_reset          = 8'h00;
  localparam int          invert_bit                  = 16;
  localparam int          ramp_en_bit                 = 0;
  localparam int          ramp_rate_bit               = 1;
  localparam int          ramp_period_cycles          = 256;
  localparam int          abrupt_update_max_cycles    = 1024;
  localparam logic [7:0]  fast_step                   = 8'h04;
  localparam logic [7:0]  slow_step                   = 8'h01;
  localparam logic [1:0]  abrupt_delay_cycles         = 2'h2;
endpackage

// ===== hdl/aperture_delay_ramp_ctrl.sv
// Purpose: aperture delay register file with coarse delay ramp engine
// Assumes: single device clock, avalon-mm slave with waitrequest
// Notes: every access answers in its second cycle; a write lands on the edge that ends that second cycle
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
module aperture_delay_ramp_ctrl
  import aperture_delay_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // calibration engine
  input  wire logic        ref_pulse_cal_enable,
  input  wire logic [16:0] calibrated_delay_result,
  input  wire logic        ref_pulse_cal_complete,
  // delay line controls
  output logic             sample_clock_invert,
  output logic      [7:0]  applied_coarse,
  output logic      [7:0]  applied_fine,
  output logic             ramp_busy
);
  import aperture_delay_pkg::*;

  logic [23:0] delay_setting_r;
  logic [7:0]  ramp_ctrl_r;
  logic [7:0]  coarse_r;
  logic [7:0]  coarse_nxt;
  logic [7:0]  fine_r;
  logic        invert_r;
  logic [7:0]  tick_cnt_r;
  logic [1:0]  abrupt_cnt_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        ramping_r;

  wire logic       req      = avs_read | avs_write;
  wire logic       wr_fire  = avs_write & ack_r;
  wire logic       wr_delay = wr_fire & (avs_address == aperture_delay_setting_offs);
  wire logic       wr_ramp  = wr_fire & (avs_address == delay_ramp_control_offs);
  wire logic [7:0] target   = delay_setting_r[15:8];
  wire logic       tick     = (tick_cnt_r == 8'(ramp_period_cycles - 1));
  wire logic [7:0] step     = ramp_ctrl_r[ramp_rate_bit] ? fast_step : slow_step;

  // one wait cycle, then the answer
  assign avs_waitrequest = req & ~ack_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  // byte-lane writes; reserved bits stay writable
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      delay_setting_r <= delay_setting_reset;
    else if (wr_delay)
    begin
      for (int i = 0; i < 3; i++)
        if (avs_byteenable[i])
          delay_setting_r[i*8 +: 8] <= avs_writedata[i*8 +: 8];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ramp_ctrl_r <= ramp_control_reset;
    else if (wr_ramp && avs_byteenable[0])
      ramp_ctrl_r <= avs_writedata[7:0];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rdata_r <= 32'h0;
    else if (avs_read && !ack_r)
    begin
      unique case (avs_address)
        aperture_delay_setting_offs: rdata_r <= {8'h0, delay_setting_r};
        delay_ramp_control_offs:     rdata_r <= {24'h0, ramp_ctrl_r};
        cal_status_offs:             rdata_r <= {14'h0, ref_pulse_cal_complete,
                                                 calibrated_delay_result};
        applied_delay_offs:          rdata_r <= {14'h0, ramping_r, invert_r,
                                                 coarse_r, fine_r};
        default:                     rdata_r <= 32'h0;
      endcase
    end
  end
  assign avs_readdata = rdata_r;

  // free-running ramp period divider
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tick_cnt_r <= 8'h0;
    else
      tick_cnt_r <= tick_cnt_r + 8'h1;
  end

  // abrupt mode delay: well inside the allowed window, keeps glitch-free ordering
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      abrupt_cnt_r <= 2'h0;
    else if (wr_delay)
      abrupt_cnt_r <= abrupt_delay_cycles;
    else if (abrupt_cnt_r != 2'h0)
      abrupt_cnt_r <= abrupt_cnt_r - 2'h1;
  end

  // coarse step never overshoots the target
  always_comb
  begin
    coarse_nxt = coarse_r;
    if (!ramp_ctrl_r[ramp_en_bit])
    begin
      if (abrupt_cnt_r != abrupt_delay_cycles)
        coarse_nxt = target;
    end
    else if (tick && coarse_r != target)
    begin
      if (target > coarse_r)
        coarse_nxt = (target - coarse_r > step) ? coarse_r + step : target;
      else
        coarse_nxt = (coarse_r - target > step) ? coarse_r - step : target;
    end
  end

  // manual path; ramp retargets from coarse_r on any new write
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      coarse_r <= 8'h0;
    else
      coarse_r <= coarse_nxt;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fine_r    <= 8'h0;
      invert_r  <= 1'b0;
      ramping_r <= 1'b0;
    end
    else
    begin
      fine_r    <= delay_setting_r[7:0];
      invert_r  <= delay_setting_r[invert_bit];
      ramping_r <= ramp_ctrl_r[ramp_en_bit] && (coarse_nxt != target);
    end
  end

  // calibration overrides manual value once complete
  wire logic use_cal = ref_pulse_cal_enable & ref_pulse_cal_complete;

  assign applied_coarse      = ref_pulse_cal_enable ?
                               (use_cal ? calibrated_delay_result[15:8] : coarse_r)
                               : coarse_r;
  assign applied_fine        = use_cal ? calibrated_delay_result[7:0] : fine_r;
  assign sample_clock_invert = use_cal ? calibrated_delay_result[16] : invert_r;
  assign ramp_busy           = ramping_r;

  a_invert_follows: assert property (@(posedge sys_clk) disable iff (rst)
    !ref_pulse_cal_enable |-> (sample_clock_invert == $past(delay_setting_r[invert_bit])))
    else $error("invert does not follow bit 16");

  a_manual_coarse: assert property (@(posedge sys_clk) disable iff (rst)
    !ref_pulse_cal_enable |-> applied_coarse == coarse_r)
    else $error("manual coarse not applied");

  a_cal_result: assert property (@(posedge sys_clk) disable iff (rst)
    (ref_pulse_cal_enable && ref_pulse_cal_complete) |->
    {sample_clock_invert, applied_coarse, applied_fine} == calibrated_delay_result)
    else $error("calibrated value not applied");

  a_fine_follows: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(delay_setting_r[7:0]) |=> fine_r == $past(delay_setting_r[7:0]))
    else $error("fine code not applied");

  a_abrupt_update: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_delay && !ramp_ctrl_r[ramp_en_bit]) ##1 (!wr_delay && !ramp_ctrl_r[ramp_en_bit])[*3]
    |-> coarse_r == target)
    else $error("abrupt coarse update late");

  a_ramp_holds: assert property (@(posedge sys_clk) disable iff (rst)
    (ramp_ctrl_r[ramp_en_bit] && coarse_r == target && !wr_delay) |=> $stable(coarse_r))
    else $error("ramp moved after reaching target");

  a_ramp_rate: assert property (@(posedge sys_clk) disable iff (rst)
    (ramp_ctrl_r[ramp_en_bit] && $changed(coarse_r)) |->
    ($past(tick) && ((coarse_r > $past(coarse_r) ? coarse_r - $past(coarse_r)
                    : $past(coarse_r) - coarse_r) <= $past(step))))
    else $error("ramp step too large or off period");

  a_ramp_reset: assert property (@(posedge sys_clk)
    rst |=> ramp_ctrl_r == ramp_control_reset)
    else $error("ramp control not reset");

  a_setting_reset: assert property (@(posedge sys_clk)
    rst |=> delay_setting_r == delay_setting_reset)
    else $error("delay setting not reset");

  a_no_jump: assert property (@(posedge sys_clk) disable iff (rst)
    (ramp_ctrl_r[ramp_en_bit] && wr_delay) |=> $stable(coarse_r) || $past(tick))
    else $error("coarse jumped on retarget");

  a_wait_single: assert property (@(posedge sys_clk) disable iff (rst)
    (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");

  a_read_setting: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read && !avs_waitrequest && avs_address == aperture_delay_setting_offs) |->
    avs_readdata == {8'h0, delay_setting_r})
    else $error("delay setting read mismatch");

  a_read_ramp: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read && !avs_waitrequest && avs_address == delay_ramp_control_offs) |->
    avs_readdata == {24'h0, ramp_ctrl_r})
    else $error("ramp control read mismatch");

  a_read_unmapped: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read && !avs_waitrequest && avs_address != aperture_delay_setting_offs &&
     avs_address != delay_ramp_control_offs && avs_address != cal_status_offs &&
     avs_address != applied_delay_offs) |->
    avs_readdata == 32'h0)
    else $error("unmapped read not zero");

  a_coarse_write: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_write && !avs_waitrequest && avs_address == aperture_delay_setting_offs &&
     avs_byteenable[1]) |=> delay_setting_r[15:8] == $past(avs_writedata[15:8]))
    else $error("coarse code write lost");

  a_fine_write: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_write && !avs_waitrequest && avs_address == aperture_delay_setting_offs &&
     avs_byteenable[0]) |=> delay_setting_r[7:0] == $past(avs_writedata[7:0]))
    else $error("fine code write lost");

  a_reserved_write: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_write && !avs_waitrequest && avs_address == aperture_delay_setting_offs &&
     avs_byteenable[2]) |=> delay_setting_r[23:16] == $past(avs_writedata[23:16]))
    else $error("upper setting byte write lost");

  a_ramp_write: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_write && !avs_waitrequest && avs_address == delay_ramp_control_offs &&
     avs_byteenable[0]) |=> ramp_ctrl_r == $past(avs_writedata[7:0]))
    else $error("ramp control write lost");

  a_unmapped_write: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_write && !avs_waitrequest && avs_address != aperture_delay_setting_offs &&
     avs_address != delay_ramp_control_offs) |=>
    ($stable(delay_setting_r) && $stable(ramp_ctrl_r)))
    else $error("unmapped write changed a register");

  a_overshoot_up: assert property (@(posedge sys_clk) disable iff (rst)
    (ramp_ctrl_r[ramp_en_bit] && coarse_r < target && !wr_delay) |=> coarse_r <= target)
    else $error("ramp overshot upward");

  a_overshoot_down: assert property (@(posedge sys_clk) disable iff (rst)
    (ramp_ctrl_r[ramp_en_bit] && coarse_r > target && !wr_delay) |=> coarse_r >= target)
    else $error("ramp overshot downward");

  a_busy_on: assert property (@(posedge sys_clk) disable iff (rst)
    (ramp_ctrl_r[ramp_en_bit] && coarse_r != target && !tick) |=> ramp_busy)
    else $error("busy low while ramp pending");

  a_busy_off: assert property (@(posedge sys_clk) disable iff (rst)
    !ramp_ctrl_r[ramp_en_bit] |=> !ramp_busy)
    else $error("busy high with ramp disabled");

  a_step_taken: assert property (@(posedge sys_clk) disable iff (rst)
    (ramp_ctrl_r[ramp_en_bit] && tick && coarse_r != target) |=> $changed(coarse_r))
    else $error("ramp period passed without a step");

  a_abrupt_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    (!ramp_ctrl_r[ramp_en_bit] && abrupt_cnt_r == abrupt_delay_cycles) |=> $stable(coarse_r))
    else $error("coarse moved before its update slot");

  a_cal_pending: assert property (@(posedge sys_clk) disable iff (rst)
    (ref_pulse_cal_enable && !ref_pulse_cal_complete) |->
    {sample_clock_invert, applied_coarse, applied_fine} == {invert_r, coarse_r, fine_r})
    else $error("incomplete calibration result applied");

  a_fine_manual: assert property (@(posedge sys_clk) disable iff (rst)
    !ref_pulse_cal_enable |-> applied_fine == fine_r)
    else $error("manual fine code not applied");

  // age of a manual code still waiting with ramping off; saturates so it cannot wrap
  logic [10:0] pend_age_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pend_age_r <= 11'h0;
    else if (wr_delay || ramp_ctrl_r[ramp_en_bit] || coarse_r == target)
      pend_age_r <= 11'h0;
    else if (pend_age_r != 11'h7ff)
      pend_age_r <= pend_age_r + 11'h1;
  end

  a_abrupt_window: assert property (@(posedge sys_clk) disable iff (rst)
    pend_age_r < 11'(abrupt_update_max_cycles))
    else $error("coarse code not applied in time");
endmodule

// ===== verif/aperture_delay_ramp_ctrl_test.sv
// Purpose: self-checking bench for the aperture delay ramp controller
// Assumes: avalon-mm master waits on waitrequest; fixed seed
// Notes: settled values are sampled at the falling edge to avoid races
`timescale 1ns/1ps
module aperture_delay_ramp_ctrl_test;
  import aperture_delay_pkg::*;
  logic        sys_clk, rst, avs_read, avs_write, ws, cen, cdone, inv, si, busy, sb;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rs, rd;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest;
  logic [16:0] cres;
  logic [7:0]  ac, af, sc, sf;
  int          miscompares, n_compared, i;

  aperture_delay_ramp_ctrl dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ref_pulse_cal_enable(cen),
    .calibrated_delay_result(cres), .ref_pulse_cal_complete(cdone),
    .sample_clock_invert(inv), .applied_coarse(ac), .applied_fine(af), .ramp_busy(busy));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // values seen at the falling edge are still those present at the next rising edge
  always @(negedge sys_clk)
  begin
    ws = avs_waitrequest;
    rs = avs_readdata;
    sc = ac;
    sf = af;
    si = inv;
    sb = busy;
  end

  task automatic complete_run;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // called just after a rising edge; holds the request until waitrequest is low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (ws !== 1'b0 && n < 50);
    if (!wr) rd = rs;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50)
    begin
      miscompares++;
      complete_run();
    end
    @(posedge sys_clk);
  endtask

  // follows a ramp, checking size and direction of each step and spacing of every step after the first
  task automatic ramp(input logic [7:0] tgt, input int stp, input int nmax);
    logic [7:0] p;
    int         gap, nst, d, rem, first, k;
    p = sc;
    gap = 0;
    nst = 0;
    first = 1;
    for (k = 0; k < 6000 && sc !== tgt && nst < nmax; k++)
    begin
      @(posedge sys_clk);
      gap++;
      if (sc !== p)
      begin
        rem = (tgt > p) ? tgt - p : p - tgt;
        d = (sc > p) ? sc - p : p - sc;
        chk(d, (rem < stp) ? rem : stp, "step size");
        chk(sc > p, tgt > p, "step direction");
        if (sc !== tgt) chk(sb, 1'b1, "busy in ramp");
        if (!first) chk(gap, ramp_period_cycles, "step spacing");
        first = 0;
        gap = 0;
        p = sc;
        nst++;
      end
    end
    if (nmax > 50) chk(sc, tgt, "ramp target");
  endtask

  initial
  begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    cen = 1'b0;
    cdone = 1'b0;
    cres = 17'h0;
    miscompares = 0;
    n_compared = 0;
    i = $urandom(32'h2e8cbb52);
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(0, aperture_delay_setting_offs, 0);
    chk(rd, delay_setting_reset, "setting reset");
    bus(0, delay_ramp_control_offs, 0);
    chk(rd, ramp_control_reset, "ramp ctrl reset");
    bus(0, 12'h3f0, 0);
    chk(rd, 32'h0, "unmapped read");
    bus(1, aperture_delay_setting_offs, 32'h00ab005a);
    bus(0, aperture_delay_setting_offs, 0);
    chk(rd, 32'h00ab005a, "reserved field");
    chk(si, 1'b1, "invert set");
    chk(sf, 8'h5a, "fine code");
    bus(1, aperture_delay_setting_offs, 32'h0);
    @(posedge sys_clk);
    chk(si, 1'b0, "invert clear");
    avs_byteenable <= 4'h1;
    bus(1, aperture_delay_setting_offs, 32'h00ffff77);
    avs_byteenable <= 4'hf;
    bus(1, 12'h3f0, 32'hffffffff);
    bus(0, aperture_delay_setting_offs, 0);
    chk(rd, 32'h00000077, "lane and unmapped writes");
    repeat (3)
    begin
      rd = {16'h0, 8'($urandom), 8'h00};
      bus(1, aperture_delay_setting_offs, rd);
      for (i = 0; i < abrupt_update_max_cycles && sc !== rd[15:8]; i++) @(posedge sys_clk);
      chk(sc, rd[15:8], "abrupt update");
    end
    bus(1, aperture_delay_setting_offs, 32'h4000);
    for (i = 0; i < abrupt_update_max_cycles && sc !== 8'h40; i++) @(posedge sys_clk);
    chk(sc, 8'h40, "abrupt update");
    bus(1, delay_ramp_control_offs, 32'hfc);
    bus(0, delay_ramp_control_offs, 0);
    chk(rd, 32'hfc, "ramp ctrl reserved");
    bus(1, delay_ramp_control_offs, 32'h1);
    bus(1, aperture_delay_setting_offs, 32'h4300);
    ramp(8'h43, 1, 99);
    repeat (600) @(posedge sys_clk);
    chk(sc, 8'h43, "ramp stopped");
    chk(sb, 1'b0, "busy cleared");
    bus(0, applied_delay_offs, 0);
    chk(rd, 32'h00004300, "applied readback");
    bus(1, delay_ramp_control_offs, 32'h3);
    bus(1, aperture_delay_setting_offs, 32'h3900);
    ramp(8'h39, 4, 99);
    bus(1, delay_ramp_control_offs, 32'h1);
    bus(1, aperture_delay_setting_offs, 32'h4100);
    ramp(8'h41, 1, 2);
    bus(1, aperture_delay_setting_offs, 32'h3000);
    ramp(8'h30, 1, 99);
    bus(1, delay_ramp_control_offs, 32'h0);
    cres <= 17'($urandom);
    cen <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(sc, 8'h30, "cal pending");
    cdone <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({si, sc, sf}, cres, "cal result");
    bus(0, cal_status_offs, 0);
    chk(rd, {14'h0, 1'b1, cres}, "cal status");
    bus(1, aperture_delay_setting_offs, 32'h3100);
    repeat (4) @(posedge sys_clk);
    chk({si, sc, sf}, cres, "manual ignored");
    cen <= 1'b0;
    cdone <= 1'b0;
    for (i = 0; i < abrupt_update_max_cycles && sc !== 8'h31; i++) @(posedge sys_clk);
    chk(sc, 8'h31, "manual restored");
    complete_run();
  end
endmodule
